/* File: logic/flshc_pkg.sv */
// shared constants of the flash OTP and buffered program controller
package flshc_pkg;

  // system clock
  localparam int CLK_PERIOD_NS = 20;

  // flash bus timing, least times in ns, cycle counts rounded up
  localparam int T_ADDR_SETUP_NS = 10;
  localparam int T_WRITE_PULSE_NS = 45;
  localparam int T_READ_ACCESS_NS = 80;
  localparam int T_HOLD_NS = 30;
  localparam int CYC_SETUP = (T_ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_WPULSE = (T_WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_RPULSE = (T_READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_HOLD = (T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] CYC_SETUP_L = 4'(CYC_SETUP);
  localparam logic [3:0] CYC_WPULSE_L = 4'(CYC_WPULSE);
  localparam logic [3:0] CYC_RPULSE_L = 4'(CYC_RPULSE);
  localparam logic [3:0] CYC_HOLD_L = 4'(CYC_HOLD);

  // software register byte offsets
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_BASE = 8'h04;
  localparam logic [7:0] REG_COUNT = 8'h08;
  localparam logic [7:0] REG_DATA = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_IRQ_STAT = 8'h14;
  localparam logic [7:0] REG_IRQ_CLR = 8'h18;
  localparam logic [7:0] REG_IRQ_EN = 8'h1C;

  // command register fields
  localparam int CMD_GO_BIT = 0;
  localparam int CMD_OP_LSB = 1;
  localparam logic [2:0] OP_WBUF_PROG = 3'h1;
  localparam logic [2:0] OP_EBUF_PROG = 3'h2;
  localparam logic [2:0] OP_EXT_PROG = 3'h3;
  localparam logic [2:0] OP_EXT_PROTECT = 3'h4;
  localparam logic [2:0] OP_LOCK_READ = 3'h5;

  // status register fields
  localparam int ST_BUSY = 0;
  localparam int ST_LOCK_ORIGIN = 1;
  localparam int ST_PROTECTED = 2;
  localparam int ST_LOCK_KNOWN = 3;
  localparam int ST_RES_LSB = 4;
  localparam logic [1:0] RES_OK = 2'h0;
  localparam logic [1:0] RES_FAIL = 2'h1;
  localparam logic [1:0] RES_ABORT = 2'h2;

  // interrupt bits
  localparam int IRQ_W = 4;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_FAIL = 1;
  localparam int IRQ_ABORT = 2;
  localparam int IRQ_REFUSED = 3;

  // flash data bits
  localparam int LOCK_ORIGIN_IND_BIT = 7;
  localparam int DATA_POLL_BIT = 7;
  localparam int ERROR_FLAG_BIT = 5;
  localparam int BUFFER_ABORT_FLAG_BIT = 1;

  // buffer sizes and address shapes
  localparam logic [7:0] WBUF_LAST = 8'h1F;
  localparam logic [7:0] EBUF_LAST = 8'hFF;
  localparam logic [7:0] EXT_LAST = 8'h7F;
  localparam logic [23:0] WBUF_PAGE_MASK = 24'h00001F;
  localparam logic [23:0] EBUF_BLOCK_MASK = 24'hFFFF00;

  // command cycles
  localparam logic [23:0] UNLK1_ADDR = 24'h000555;
  localparam logic [15:0] UNLK1_DATA = 16'h00AA;
  localparam logic [23:0] UNLK2_ADDR = 24'h0002AA;
  localparam logic [15:0] UNLK2_DATA = 16'h0055;
  localparam logic [15:0] WBUF_CMD = 16'h0025;
  localparam logic [15:0] EBUF_CMD = 16'h0033;
  localparam logic [15:0] CONFIRM_CMD = 16'h0029;
  localparam logic [15:0] RESET_CMD = 16'h00F0;
  localparam logic [15:0] WBUF_ABORT_CMD = 16'h00F0;
  localparam logic [15:0] EBUF_ABORT_CMD = 16'h0090;
  localparam logic [15:0] EXT_ENTER_CMD = 16'h0088;
  localparam logic [15:0] EXT_EXIT_CMD = 16'h0090;
  localparam logic [15:0] EXT_EXIT2_CMD = 16'h0000;
  localparam logic [15:0] AUTOSEL_CMD = 16'h0090;
  localparam logic [15:0] WPROG_CMD = 16'h00A0;
  localparam logic [23:0] IND_ADDR = 24'h000003;
  localparam logic [23:0] PROT_ADDR = 24'h000000;
  localparam logic [15:0] PROT_DATA = 16'hFFFE;
  localparam logic [23:0] ZERO_ADDR = 24'h000000;

endpackage : flshc_pkg

/* File: logic/flshc_cycle.sv */
// one asynchronous flash bus cycle, write or read, on the flash pins
`timescale 1ns/1ps
module flshc_cycle (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // request from the sequencer
  input wire logic start_i,
  input wire logic we_i,
  input wire logic [23:0] addr_i,
  input wire logic [15:0] data_i,
  output logic busy_o,
  output logic done_o,
  output logic [15:0] rdata_o,
  // flash pins
  output logic [23:0] fl_addr_o,
  input wire logic [15:0] fl_dq_i,
  output logic [15:0] fl_dq_o,
  output logic fl_dq_oe_o,
  output logic fl_ce_n_o,
  output logic fl_oe_n_o,
  output logic fl_we_n_o
);

  typedef enum logic [3:0] {
    C_IDLE = 4'b0001,
    C_SETUP = 4'b0010,
    C_STROBE = 4'b0100,
    C_HOLD = 4'b1000
  } flshc_cyc_e;

  flshc_cyc_e cst;
  logic [3:0] cnt;
  logic is_write;

  assign busy_o = (cst != C_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cst <= C_IDLE;
      cnt <= 4'h0;
      is_write <= 1'b0;
      done_o <= 1'b0;
      rdata_o <= 16'h0000;
      fl_addr_o <= 24'h000000;
      fl_dq_o <= 16'h0000;
      fl_dq_oe_o <= 1'b0;
      fl_ce_n_o <= 1'b1;
      fl_oe_n_o <= 1'b1;
      fl_we_n_o <= 1'b1;
    end else begin
      done_o <= 1'b0;
      case (cst)
        C_IDLE: begin
          if (start_i) begin
            is_write <= we_i;
            fl_addr_o <= addr_i;
            fl_dq_o <= data_i;
            fl_dq_oe_o <= we_i;
            fl_ce_n_o <= 1'b0;
            cnt <= flshc_pkg::CYC_SETUP_L;
            cst <= C_SETUP;
          end
        end
        C_SETUP: begin
          if (cnt <= 4'h1) begin
            fl_we_n_o <= ~is_write;
            fl_oe_n_o <= is_write;
            cnt <= is_write ? flshc_pkg::CYC_WPULSE_L
                            : flshc_pkg::CYC_RPULSE_L;
            cst <= C_STROBE;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        C_STROBE: begin
          if (cnt <= 4'h1) begin
            // sample at the end of the access time, before oe rises
            if (!is_write) begin
              rdata_o <= fl_dq_i;
            end
            fl_we_n_o <= 1'b1;
            fl_oe_n_o <= 1'b1;
            cnt <= flshc_pkg::CYC_HOLD_L;
            cst <= C_HOLD;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        C_HOLD: begin
          if (cnt <= 4'h1) begin
            fl_dq_oe_o <= 1'b0;
            fl_ce_n_o <= 1'b1;
            done_o <= 1'b1;
            cst <= C_IDLE;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        default: begin
          cst <= C_IDLE;
        end
      endcase
    end
  end

endmodule : flshc_cycle

/* File: logic/flshc_top.sv */
// host controller: OTP extended block locking and buffered program flows
// Function
// - host protects extended block by programming protect bit to zero.
// - after extended block programming, issue exit command back to read (an abort flag on the recheck ends with abort-and-reset, no exit).
// - write-to-buffer loads exactly n+1 address/data pairs before confirm.
// - buffer data addresses stay within one write buffer page.
// - after error flag seen, read data-polling bit once more.
// - buffer program: error gets reset, abort gets abort-and-reset.
// - enhanced program addresses start at block offset 00, consecutive.
// - enhanced program: error gets reset, abort gets its abort-reset.
`timescale 1ns/1ps
module flshc_top (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // software register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  output logic irq_o,
  // flash pins
  output logic [23:0] fl_addr_o,
  input wire logic [15:0] fl_dq_i,
  output logic [15:0] fl_dq_o,
  output logic fl_dq_oe_o,
  output logic fl_ce_n_o,
  output logic fl_oe_n_o,
  output logic fl_we_n_o
);

  typedef enum logic [11:0] {
    S_IDLE = 12'b000000000001,
    S_UNLK = 12'b000000000010,
    S_HDR = 12'b000000000100,
    S_LOAD = 12'b000000001000,
    S_CONF = 12'b000000010000,
    S_WPROG = 12'b000000100000,
    S_POLL = 12'b000001000000,
    S_RECHK = 12'b000010000000,
    S_RST = 12'b000100000000,
    S_READ = 12'b001000000000,
    S_EXITZ = 12'b010000000000,
    S_DONE = 12'b100000000000
  } flshc_state_e;

  // three-step unlock prefix, the last step carrying the command itself
  function automatic logic [39:0] flshc_unlock(input logic [1:0] step,
                                               input logic [23:0] a,
                                               input logic [15:0] d);
    case (step)
      2'h0: flshc_unlock = {flshc_pkg::UNLK1_ADDR, flshc_pkg::UNLK1_DATA};
      2'h1: flshc_unlock = {flshc_pkg::UNLK2_ADDR, flshc_pkg::UNLK2_DATA};
      default: flshc_unlock = {a, d};
    endcase
  endfunction : flshc_unlock

  function automatic logic flshc_is_ext(input logic [2:0] o);
    flshc_is_ext = (o == flshc_pkg::OP_EXT_PROG) ||
                   (o == flshc_pkg::OP_EXT_PROTECT);
  endfunction : flshc_is_ext

  flshc_state_e state;
  logic [2:0] op;
  logic [23:0] base;
  logic [7:0] count;
  logic [7:0] last;
  logic [7:0] wr_ptr;
  logic [7:0] idx;
  logic [1:0] step;
  logic [23:0] unlk_addr;
  logic [15:0] unlk_data;
  flshc_state_e unlk_next;
  logic [23:0] poll_addr;
  logic poll_d7;
  logic [1:0] result;
  logic lock_origin;
  logic lock_known;
  logic prot;
  logic cyc_wait;
  logic [15:0] wbuf [0:255];
  logic [flshc_pkg::IRQ_W-1:0] irq_stat;
  logic [flshc_pkg::IRQ_W-1:0] irq_en;
  logic [flshc_pkg::IRQ_W-1:0] ev;
  logic ev_refused;
  logic go;
  logic [2:0] go_op;
  logic refuse;

  // cycle request
  logic need_cyc;
  logic cyc_we;
  logic [23:0] cyc_addr;
  logic [15:0] cyc_data;
  logic [39:0] unlk_word;
  logic [23:0] load_addr;
  logic cyc_start;
  logic cyc_busy;
  logic cyc_done;
  logic [15:0] cyc_rdata;
  logic poll_ok;
  logic poll_err;
  logic poll_abt;

  ////////////////////////////////////////////////////////////////////////////
  // command acceptance

  assign go = wr_i && (addr_i == flshc_pkg::REG_CMD) &&
              wdata_i[flshc_pkg::CMD_GO_BIT];
  assign go_op = wdata_i[flshc_pkg::CMD_OP_LSB +: 3];

  always_comb begin
    refuse = (state != S_IDLE);
    case (go_op)
      flshc_pkg::OP_WBUF_PROG: begin
        // the whole load must sit in the page of the start address
        refuse = refuse || (count > flshc_pkg::WBUF_LAST) ||
                 ({16'h0000, count} + (base & flshc_pkg::WBUF_PAGE_MASK)
                  > flshc_pkg::WBUF_PAGE_MASK);
      end
      flshc_pkg::OP_EBUF_PROG: begin
      end
      flshc_pkg::OP_EXT_PROG: begin
        refuse = refuse || prot || (count > flshc_pkg::EXT_LAST);
      end
      flshc_pkg::OP_EXT_PROTECT: begin
        refuse = refuse || prot;
      end
      flshc_pkg::OP_LOCK_READ: begin
      end
      // no erase is ever offered for the extended block
      default: refuse = 1'b1;
    endcase
  end

  assign ev_refused = go && refuse;

  ////////////////////////////////////////////////////////////////////////////
  // cycle request decode

  assign unlk_word = flshc_unlock(step, unlk_addr, unlk_data);
  assign poll_ok = (cyc_rdata[flshc_pkg::DATA_POLL_BIT] == poll_d7);
  assign poll_err = cyc_rdata[flshc_pkg::ERROR_FLAG_BIT];
  assign poll_abt = cyc_rdata[flshc_pkg::BUFFER_ABORT_FLAG_BIT];

  always_comb begin
    load_addr = base + {16'h0000, idx};
    if (op == flshc_pkg::OP_EBUF_PROG) begin
      load_addr = (base & flshc_pkg::EBUF_BLOCK_MASK) + {16'h0000, idx};
    end else if (op == flshc_pkg::OP_EXT_PROG) begin
      load_addr = {16'h0000, idx};
    end
  end

  always_comb begin
    need_cyc = 1'b1;
    cyc_we = 1'b1;
    cyc_addr = flshc_pkg::ZERO_ADDR;
    cyc_data = flshc_pkg::RESET_CMD;
    case (state)
      S_UNLK: {cyc_addr, cyc_data} = unlk_word;
      S_HDR: {cyc_addr, cyc_data} = {base, 8'h00, count};
      S_LOAD: {cyc_addr, cyc_data} = {load_addr, wbuf[idx]};
      S_CONF: {cyc_addr, cyc_data} = {base, flshc_pkg::CONFIRM_CMD};
      S_WPROG: begin
        if (step == 2'h3) begin
          if (op == flshc_pkg::OP_EXT_PROTECT) begin
            {cyc_addr, cyc_data} = {flshc_pkg::PROT_ADDR,
                                    flshc_pkg::PROT_DATA};
          end else begin
            {cyc_addr, cyc_data} = {load_addr, wbuf[idx]};
          end
        end else begin
          {cyc_addr, cyc_data} = flshc_unlock(step, flshc_pkg::UNLK1_ADDR,
                                              flshc_pkg::WPROG_CMD);
        end
      end
      S_POLL, S_RECHK: begin
        cyc_we = 1'b0;
        cyc_addr = poll_addr;
      end
      S_RST: cyc_data = flshc_pkg::RESET_CMD;
      S_READ: begin
        cyc_we = 1'b0;
        cyc_addr = flshc_pkg::IND_ADDR;
      end
      S_EXITZ: cyc_data = flshc_pkg::EXT_EXIT2_CMD;
      default: need_cyc = 1'b0;
    endcase
  end

  assign cyc_start = need_cyc && !cyc_wait && !cyc_busy;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cyc_wait <= 1'b0;
    end else if (cyc_done) begin
      cyc_wait <= 1'b0;
    end else if (cyc_start) begin
      cyc_wait <= 1'b1;
    end
  end

  flshc_cycle i_flshc_cycle (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .start_i(cyc_start),
    .we_i(cyc_we),
    .addr_i(cyc_addr),
    .data_i(cyc_data),
    .busy_o(cyc_busy),
    .done_o(cyc_done),
    .rdata_o(cyc_rdata),
    .fl_addr_o(fl_addr_o),
    .fl_dq_i(fl_dq_i),
    .fl_dq_o(fl_dq_o),
    .fl_dq_oe_o(fl_dq_oe_o),
    .fl_ce_n_o(fl_ce_n_o),
    .fl_oe_n_o(fl_oe_n_o),
    .fl_we_n_o(fl_we_n_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= S_IDLE;
      op <= 3'h0;
      last <= 8'h00;
      idx <= 8'h00;
      step <= 2'h0;
      unlk_addr <= flshc_pkg::ZERO_ADDR;
      unlk_data <= flshc_pkg::RESET_CMD;
      unlk_next <= S_DONE;
      poll_addr <= flshc_pkg::ZERO_ADDR;
      poll_d7 <= 1'b0;
      result <= flshc_pkg::RES_OK;
    end else begin
      case (state)
        S_IDLE: begin
          if (go && !refuse) begin
            op <= go_op;
            idx <= 8'h00;
            step <= 2'h0;
            result <= flshc_pkg::RES_OK;
            state <= S_UNLK;
            unlk_addr <= flshc_pkg::UNLK1_ADDR;
            last <= (go_op == flshc_pkg::OP_EBUF_PROG) ?
                    flshc_pkg::EBUF_LAST : count;
            case (go_op)
              flshc_pkg::OP_WBUF_PROG: begin
                unlk_addr <= base;
                unlk_data <= flshc_pkg::WBUF_CMD;
                unlk_next <= S_HDR;
              end
              flshc_pkg::OP_EBUF_PROG: begin
                unlk_addr <= base;
                unlk_data <= flshc_pkg::EBUF_CMD;
                unlk_next <= S_LOAD;
              end
              flshc_pkg::OP_LOCK_READ: begin
                unlk_data <= flshc_pkg::AUTOSEL_CMD;
                unlk_next <= S_READ;
              end
              default: begin
                unlk_data <= flshc_pkg::EXT_ENTER_CMD;
                unlk_next <= S_WPROG;
              end
            endcase
          end
        end
        S_UNLK: begin
          if (cyc_done) begin
            step <= step + 2'h1;
            if (step == 2'h2) begin
              step <= 2'h0;
              state <= unlk_next;
            end
          end
        end
        S_HDR: begin
          if (cyc_done) begin
            state <= S_LOAD;
          end
        end
        S_LOAD: begin
          if (cyc_done) begin
            // exactly last+1 words go out before the confirm
            if (idx == last) begin
              poll_addr <= load_addr;
              poll_d7 <= wbuf[idx][flshc_pkg::DATA_POLL_BIT];
              state <= S_CONF;
            end else begin
              idx <= idx + 8'h01;
            end
          end
        end
        S_CONF: begin
          if (cyc_done) begin
            state <= S_POLL;
          end
        end
        S_WPROG: begin
          if (cyc_done) begin
            step <= step + 2'h1;
            if (step == 2'h3) begin
              poll_addr <= cyc_addr;
              poll_d7 <= cyc_data[flshc_pkg::DATA_POLL_BIT];
              state <= S_POLL;
            end
          end
        end
        S_POLL, S_RECHK: begin
          if (cyc_done) begin
            if (poll_ok) begin
              if (op == flshc_pkg::OP_EXT_PROG && idx != last) begin
                idx <= idx + 8'h01;
                step <= 2'h0;
                state <= S_WPROG;
              end else if (flshc_is_ext(op)) begin
                unlk_addr <= flshc_pkg::UNLK1_ADDR;
                unlk_data <= flshc_pkg::EXT_EXIT_CMD;
                unlk_next <= S_EXITZ;
                state <= S_UNLK;
              end else begin
                state <= S_DONE;
              end
            end else if ((poll_err || poll_abt) && state == S_POLL) begin
              // the two flags can move in the same read; look again
              state <= S_RECHK;
            end else if (poll_err && state == S_RECHK) begin
              result <= flshc_pkg::RES_FAIL;
              state <= S_RST;
            end else if (poll_abt && state == S_RECHK) begin
              result <= flshc_pkg::RES_ABORT;
              unlk_addr <= flshc_pkg::UNLK1_ADDR;
              unlk_data <= (op == flshc_pkg::OP_EBUF_PROG) ?
                           flshc_pkg::EBUF_ABORT_CMD :
                           flshc_pkg::WBUF_ABORT_CMD;
              unlk_next <= S_DONE;
              state <= S_UNLK;
            end else begin
              state <= S_POLL;
            end
          end
        end
        S_RST: begin
          if (cyc_done) begin
            if (flshc_is_ext(op)) begin
              unlk_addr <= flshc_pkg::UNLK1_ADDR;
              unlk_data <= flshc_pkg::EXT_EXIT_CMD;
              unlk_next <= S_EXITZ;
              state <= S_UNLK;
            end else begin
              state <= S_DONE;
            end
          end
        end
        S_READ: begin
          if (cyc_done) begin
            state <= S_RST;
          end
        end
        S_EXITZ: begin
          if (cyc_done) begin
            state <= S_DONE;
          end
        end
        S_DONE: state <= S_IDLE;
        default: state <= S_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // lock knowledge: prot only ever moves toward protected, until the next reset clears it

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      lock_origin <= 1'b0;
      lock_known <= 1'b0;
      prot <= 1'b0;
    end else if (state == S_READ && cyc_done) begin
      lock_origin <= cyc_rdata[flshc_pkg::LOCK_ORIGIN_IND_BIT];
      lock_known <= 1'b1;
      if (cyc_rdata[flshc_pkg::LOCK_ORIGIN_IND_BIT]) begin
        prot <= 1'b1;
      end
    end else if (state == S_DONE && op == flshc_pkg::OP_EXT_PROTECT &&
                 result == flshc_pkg::RES_OK) begin
      prot <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software registers

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      base <= 24'h000000;
      count <= 8'h00;
      wr_ptr <= 8'h00;
      irq_en <= {flshc_pkg::IRQ_W{1'b0}};
    end else begin
      if (wr_i && addr_i == flshc_pkg::REG_BASE) begin
        base <= wdata_i[23:0];
      end
      if (wr_i && addr_i == flshc_pkg::REG_COUNT) begin
        count <= wdata_i[7:0];
        wr_ptr <= 8'h00;
      end else if (wr_i && addr_i == flshc_pkg::REG_DATA) begin
        wr_ptr <= wr_ptr + 8'h01;
      end
      if (wr_i && addr_i == flshc_pkg::REG_IRQ_EN) begin
        irq_en <= wdata_i[flshc_pkg::IRQ_W-1:0];
      end
    end
  end

  // buffer memory has no reset; software loads it before every run
  always_ff @(posedge sys_clk_i) begin
    if (wr_i && addr_i == flshc_pkg::REG_DATA) begin
      wbuf[wr_ptr] <= wdata_i[15:0];
    end
  end

  always_comb begin
    ev = {flshc_pkg::IRQ_W{1'b0}};
    ev[flshc_pkg::IRQ_REFUSED] = ev_refused;
    if (state == S_DONE) begin
      ev[flshc_pkg::IRQ_DONE] = 1'b1;
      ev[flshc_pkg::IRQ_FAIL] = (result == flshc_pkg::RES_FAIL);
      ev[flshc_pkg::IRQ_ABORT] = (result == flshc_pkg::RES_ABORT);
    end
  end

  // a new event in the clearing cycle stays set
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_stat <= {flshc_pkg::IRQ_W{1'b0}};
    end else if (wr_i && addr_i == flshc_pkg::REG_IRQ_CLR) begin
      irq_stat <= (irq_stat & ~wdata_i[flshc_pkg::IRQ_W-1:0]) | ev;
    end else begin
      irq_stat <= irq_stat | ev;
    end
  end

  assign irq_o = |(irq_stat & irq_en);

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 32'h00000000;
    end else begin
      rdata_o <= 32'h00000000;
      if (rd_i) begin
        case (addr_i)
          flshc_pkg::REG_BASE: rdata_o <= {8'h00, base};
          flshc_pkg::REG_COUNT: rdata_o <= {24'h000000, count};
          flshc_pkg::REG_STATUS: begin
            rdata_o[flshc_pkg::ST_BUSY] <= (state != S_IDLE);
            rdata_o[flshc_pkg::ST_LOCK_ORIGIN] <= lock_origin;
            rdata_o[flshc_pkg::ST_PROTECTED] <= prot;
            rdata_o[flshc_pkg::ST_LOCK_KNOWN] <= lock_known;
            rdata_o[flshc_pkg::ST_RES_LSB +: 2] <= result;
          end
          flshc_pkg::REG_IRQ_STAT: rdata_o <= {28'h0000000, irq_stat};
          flshc_pkg::REG_IRQ_EN: rdata_o <= {28'h0000000, irq_en};
          default: rdata_o <= 32'h00000000;
        endcase
      end
    end
  end

endmodule : flshc_top

/* File: testbench/flshc_top_asserts.sv */
// flash pin cycle checks
`timescale 1ns/1ps
module flshc_top_asserts (
  // watched ports
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [23:0] fl_addr_o,
  input wire logic [15:0] fl_dq_o,
  input wire logic fl_dq_oe_o,
  input wire logic fl_ce_n_o,
  input wire logic fl_oe_n_o,
  input wire logic fl_we_n_o
);
  default clocking @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);
  sequence wr_pulse;
    !fl_we_n_o [*3] ##1 fl_we_n_o;
  endsequence
  sequence rd_pulse;
    !fl_oe_n_o [*4] ##1 fl_oe_n_o;
  endsequence
  sequence hold_end;
    !fl_ce_n_o [*2] ##1 fl_ce_n_o;
  endsequence
  a_write_pulse: assert property (
    $fell(fl_we_n_o) |-> wr_pulse) else $error("we len");
  a_read_pulse: assert property (
    $fell(fl_oe_n_o) |-> rd_pulse) else $error("oe len");
  a_strobe_hold: assert property (
    $rose(fl_we_n_o) || $rose(fl_oe_n_o) |-> hold_end) else $error("hold");
  a_we_in_ce: assert property (
    !fl_we_n_o |-> !fl_ce_n_o) else $error("we");
  a_oe_quiet: assert property (
    !fl_oe_n_o |-> !fl_dq_oe_o && fl_we_n_o) else $error("oe");
  a_addr_hold: assert property (
    !fl_ce_n_o && $past(!fl_ce_n_o) |-> $stable(fl_addr_o)) else $error("a");
  a_data_hold: assert property (
    fl_dq_oe_o && $past(fl_dq_oe_o) |-> $stable(fl_dq_o)) else $error("d");
  a_ce_gap: assert property (
    $rose(fl_ce_n_o) |-> !fl_dq_oe_o ##1 fl_ce_n_o) else $error("gap");
endmodule : flshc_top_asserts
bind flshc_top flshc_top_asserts i_flshc_top_asserts (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .fl_addr_o(fl_addr_o),
  .fl_dq_o(fl_dq_o), .fl_dq_oe_o(fl_dq_oe_o), .fl_ce_n_o(fl_ce_n_o),
  .fl_oe_n_o(fl_oe_n_o), .fl_we_n_o(fl_we_n_o));

/* File: testbench/flshc_flash_model.sv */
// behavioural flash: mode tracking, poll status, lock state
`timescale 1ns/1ps
module flshc_flash_model (
  // flash pins, and the variant of the part
  input wire logic factory_i,
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [23:0] addr_i,
  input wire logic [15:0] dq_i,
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic [1:0] fault_i,
  output logic [15:0] dq_o
);
  logic we_q, asel;
  logic prot = 1'b0;
  logic [15:0] last, pdat, hold;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      we_q <= 1'b1;
      asel <= 1'b0;
    end else begin
      we_q <= we_n_i;
      if (!oe_n_i) hold <= dq_o;
      if (we_q && !we_n_i && !ce_n_i) begin
        last <= dq_i;
        asel <= dq_i == 16'h0090 && addr_i == 24'h000555;
        if (dq_i == 16'h0029) pdat <= last;
        if (last == 16'h00A0) pdat <= dq_i;
        // one-time and kept through reset, so never cleared
        if (last == 16'h00A0 && dq_i == 16'hFFFE) prot <= 1'b1;
      end
    end
  end
  always_comb begin
    if (oe_n_i || ce_n_i) dq_o = ~hold;
    else if (asel)
      dq_o = {8'h00, factory_i, 6'h00, ~(prot | factory_i)};
    else if (fault_i == 2'h0) dq_o = pdat;
    else dq_o = {pdat[15:8], ~pdat[7], 1'b0, fault_i == 2'h1, 3'h0,
      fault_i == 2'h2, 1'b0};
  end
endmodule : flshc_flash_model

/* File: testbench/flshc_top_bench.sv */
// random and corner tests of the flash controller
`timescale 1ns/1ps
module flshc_top_bench;
  logic clk = 0, rst = 1, wr = 0, rd = 0, fac = 0, irq, oe, ce, oen, wen;
  logic [7:0] a = 8'h00;
  logic [31:0] wd = 0, rdat, d, b, s = 32'h6C66;
  logic [23:0] fa, la;
  logic [15:0] dqo, dqi, lw;
  logic [1:0] flt = 2'h0;
  int errors = 0, tests_run = 0, nw, nr, n, f;
  initial forever #10 clk = ~clk;
  always @(negedge wen) begin
    nw++;
    lw = dqo;
    if (nw == 4) la = fa;
  end
  always @(negedge oen) nr++;
  flshc_top i_flshc_top (.sys_clk_i(clk), .rst_i(rst), .addr_i(a),
    .wdata_i(wd), .wr_i(wr), .rd_i(rd), .rdata_o(rdat), .irq_o(irq),
    .fl_addr_o(fa), .fl_dq_i(dqi), .fl_dq_o(dqo), .fl_dq_oe_o(oe),
    .fl_ce_n_o(ce), .fl_oe_n_o(oen), .fl_we_n_o(wen));
  flshc_flash_model i_flshc_flash_model (.factory_i(fac), .clk_i(clk),
    .rst_i(rst), .addr_i(fa), .dq_i(dqo), .ce_n_i(ce), .oe_n_i(oen),
    .we_n_i(wen), .fault_i(flt), .dq_o(dqi));
  function automatic logic [31:0] rnd();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : rnd
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %0t %h %h", $time, g, e);
    end
  endtask : chk
  task automatic w(input logic [7:0] x, input logic [31:0] v);
    a <= x;
    wd <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : w
  task automatic r(input logic [7:0] x);
    a <= x;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    d = rdat;
  endtask : r
  task automatic go(input logic [2:0] op);
    w(8'h18, 32'hF);
    nw = 0;
    nr = 0;
    w(8'h00, {op, 1'b1});
    d = 32'h1;
    for (int i = 0; i < 3000 && d[0] === 1'b1; i++) r(8'h10);
    chk({31'h0, d[0]}, 32'h0);
    r(8'h14);
  endtask : go
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : stop_test
  initial begin
    #1000000;
    errors++;
    stop_test();
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    w(8'h1C, 32'h0);
    go(3'h5);
    chk({31'h0, irq}, 32'h0);
    r(8'h10);
    chk(d, 32'h8);
    w(8'h1C, 32'hF);
    chk({31'h0, irq}, 32'h1);
    w(8'h0C, rnd() & 32'h7FFF);
    go(3'h3);
    chk(d, 32'h1);
    chk(nw, 11);
    go(3'h4);
    chk({16'h0, lw}, 32'h0);
    r(8'h10);
    chk(d, 32'hC);
    go(3'h4);
    chk(d, 32'h8);
    go(3'h3);
    chk(d | nw, 32'h8);
    $display("otp tests done");
    for (int k = 0; k < 7; k++) begin
      f = k % 4;
      flt <= 2'(f);
      n = k > 3 ? 255 : int'(rnd() % 31) + 1;
      b = rnd();
      // last legal page offset, or one past it
      b[4:0] = 5'(31 - n + int'(f == 3));
      w(8'h04, b);
      w(8'h08, 32'(n));
      for (int j = 0; j <= n; j++) w(8'h0C, rnd() | 32'h8000);
      go(k > 3 ? 3'h2 : 3'h1);
      chk(d, f == 3 ? 32'h8 : 32'h1 | (32'(f) << 1));
      chk(nw, f == 3 ? 0 : (k > 3 ? 260 : n + 6) + f + (f == 2));
      chk(nr, f == 3 ? 0 : 1 + (f != 0));
      if (f == 1 || f == 2)
        chk({16'h0, lw}, k > 3 && f == 2 ? 32'h90 : 32'hF0);
      if (f != 3)
        chk({8'h0, la}, b & (k > 3 ? 32'hFFFF00 : 32'hFFFFFF));
      $display("test %0d done", k);
    end
    // a second reset forgets the protection, then a factory part is read
    fac <= 1'b1;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    go(3'h5);
    r(8'h10);
    chk(d, 32'hE);
    go(3'h4);
    chk(d, 32'h8);
    $display("factory tests done");
    stop_test();
  end
endmodule : flshc_top_bench
